// ==== rtl/jtag_gp_pkg.sv ====
// Function
// - After power-up every general-purpose pin keeps its driver off and floats.
// - A general-purpose pin drives only while the general-purpose port is on and that pin is set as output.
// - Turning the general-purpose port off floats every general-purpose pin at once, whatever its direction.
// - The general-purpose port is active only while both the scan port and the serial port are off.
// - The test clock runs at the 30 MHz base divided by a host-set integer from 1 to 3750.
// - The scan engine offers the standard four-wire format (JScan), the two-slot MScan and three-slot OScan.
// - The engine runs four-wire chains and two-wire chains, where OScan uses only clock and mode-data line; MScan also reads its reply from TDO.
// - Three general-purpose pins each have their own tri-state output and a readable input.
package jtag_gp_pkg;

  localparam int GP_PINS = 3;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_MIN = 12'h001;
  localparam logic [DIV_W-1:0] DIV_MAX = 12'h0ea6;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h001;

  // Base rate doubled so that each half period of the test clock is N base ticks
  localparam int BASE_MHZ = 30;
  localparam int CORE_MHZ = 100;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_STEP = TICK_W'(2 * BASE_MHZ);
  localparam logic [TICK_W-1:0] TICK_MOD = TICK_W'(CORE_MHZ);

  typedef enum logic [1:0] {
    FMT_JSCAN = 2'b00,
    FMT_MSCAN = 2'b01,
    FMT_OSCAN = 2'b10
  } scan_fmt_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } scan_state_t;

  localparam logic [1:0] LAST_SLOT_JSCAN = 2'h0;
  localparam logic [1:0] LAST_SLOT_MSCAN = 2'h1;
  localparam logic [1:0] LAST_SLOT_OSCAN = 2'h2;

endpackage

// ==== rtl/jtag_probe_gpio_port.sv ====
module jtag_probe_gpio_port #(
  parameter int GP_PINS = jtag_gp_pkg::GP_PINS,
  parameter int DIV_W = jtag_gp_pkg::DIV_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic gp_port_en,
  input wire logic scan_en,
  input wire logic spi_en,
  input wire logic [GP_PINS-1:0] gp_dir,
  input wire logic [GP_PINS-1:0] gp_out,
  output logic [GP_PINS-1:0] gp_in_val,
  output logic gp_port_active,
  input wire jtag_gp_pkg::scan_fmt_t scan_fmt,
  input wire logic [DIV_W-1:0] clk_div_n,
  input wire logic op_valid,
  input wire logic op_tms,
  input wire logic op_tdi,
  output logic op_ready,
  output logic rsp_valid,
  output logic rsp_tdo,
  output logic tck_o,
  output logic tck_oe,
  input wire logic target_mode_data_line_i,
  output logic target_mode_data_line_o,
  output logic target_mode_data_line_oe,
  output logic tdi_o,
  output logic tdi_oe,
  input wire logic tdo_i,
  input wire logic gp_pin_zero_i,
  output logic gp_pin_zero_o,
  output logic gp_pin_zero_oe,
  input wire logic gp_pin_one_i,
  output logic gp_pin_one_o,
  output logic gp_pin_one_oe,
  // Pin two is the target processor reset when host tools need it
  input wire logic gp_pin_two_i,
  output logic gp_pin_two_o,
  output logic gp_pin_two_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // General-purpose port

  logic gp_active;
  logic gp_active_q;
  logic [GP_PINS-1:0] gp_pin_i;
  logic [GP_PINS-1:0] gp_meta_q;
  logic [GP_PINS-1:0] gp_sync_q;
  logic [GP_PINS-1:0] gp_o_q;
  logic [GP_PINS-1:0] gp_oe_q;

  assign gp_pin_i = {gp_pin_two_i, gp_pin_one_i, gp_pin_zero_i};
  assign gp_active = gp_port_en && !scan_en && !spi_en;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_active_q <= 1'b0;
    end else begin
      gp_active_q <= gp_active;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < GP_PINS; gi++) begin : g_pin
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          gp_oe_q[gi] <= 1'b0;
          gp_o_q[gi] <= 1'b0;
          gp_meta_q[gi] <= 1'b0;
          gp_sync_q[gi] <= 1'b0;
        end else begin
          // Disabling the port floats the pin regardless of its direction bit
          gp_oe_q[gi] <= gp_active && gp_dir[gi];
          gp_o_q[gi] <= gp_out[gi];
          gp_meta_q[gi] <= gp_pin_i[gi];
          gp_sync_q[gi] <= gp_meta_q[gi];
        end
      end
    end
  endgenerate

  assign gp_in_val = gp_sync_q;
  assign gp_port_active = gp_active_q;
  assign gp_pin_zero_o = gp_o_q[0];
  assign gp_pin_zero_oe = gp_oe_q[0];
  assign gp_pin_one_o = gp_o_q[1];
  assign gp_pin_one_oe = gp_oe_q[1];
  assign gp_pin_two_o = gp_o_q[2];
  assign gp_pin_two_oe = gp_oe_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine

  tck_div_if #(.DIV_W(DIV_W)) dv ();

  tck_divider #(.DIV_W(DIV_W)) u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .dv(dv.div)
  );

  jtag_gp_pkg::scan_state_t state_q;
  jtag_gp_pkg::scan_fmt_t fmt_q;
  logic [1:0] slot_q;
  logic [1:0] last_slot;
  logic [1:0] slot_next;
  logic tms_q;
  logic tdi_q;
  logic [DIV_W-1:0] div_n_q;
  logic [DIV_W-1:0] div_clamp;
  logic tdo_meta_q;
  logic tdo_sync_q;
  logic mdl_meta_q;
  logic mdl_sync_q;
  logic accept;
  logic op_ready_q;
  logic rsp_valid_q;
  logic rsp_tdo_q;
  logic tck_oe_q;
  logic mdl_o_q;
  logic mdl_oe_q;
  logic tdi_o_q;
  logic tdi_oe_q;

  assign accept = op_valid && op_ready_q && scan_en;
  assign div_clamp = (clk_div_n < jtag_gp_pkg::DIV_MIN) ? jtag_gp_pkg::DIV_MIN :
                     (clk_div_n > jtag_gp_pkg::DIV_MAX) ? jtag_gp_pkg::DIV_MAX : clk_div_n;
  assign slot_next = (dv.fall && slot_q != last_slot) ? slot_q + 2'h1 : slot_q;

  always_comb begin
    case (fmt_q)
      jtag_gp_pkg::FMT_JSCAN: last_slot = jtag_gp_pkg::LAST_SLOT_JSCAN;
      jtag_gp_pkg::FMT_MSCAN: last_slot = jtag_gp_pkg::LAST_SLOT_MSCAN;
      jtag_gp_pkg::FMT_OSCAN: last_slot = jtag_gp_pkg::LAST_SLOT_OSCAN;
      default: last_slot = jtag_gp_pkg::LAST_SLOT_JSCAN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_meta_q <= 1'b0;
      tdo_sync_q <= 1'b0;
      mdl_meta_q <= 1'b0;
      mdl_sync_q <= 1'b0;
    end else begin
      tdo_meta_q <= tdo_i;
      tdo_sync_q <= tdo_meta_q;
      mdl_meta_q <= target_mode_data_line_i;
      mdl_sync_q <= mdl_meta_q;
    end
  end

  // Divider setting frozen for a whole operation
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_n_q <= jtag_gp_pkg::DIV_RESET;
    end else if (state_q == jtag_gp_pkg::ST_IDLE) begin
      div_n_q <= div_clamp;
    end
  end

  assign dv.run = (state_q == jtag_gp_pkg::ST_RUN);
  assign dv.div_n = div_n_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= jtag_gp_pkg::ST_IDLE;
      fmt_q <= jtag_gp_pkg::FMT_JSCAN;
      slot_q <= 2'h0;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
      op_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_tdo_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        jtag_gp_pkg::ST_IDLE: begin
          if (accept) begin
            state_q <= jtag_gp_pkg::ST_RUN;
            fmt_q <= scan_fmt;
            slot_q <= 2'h0;
            tms_q <= op_tms;
            tdi_q <= op_tdi;
            op_ready_q <= 1'b0;
          end
        end
        jtag_gp_pkg::ST_RUN: begin
          if (dv.fall) begin
            // Target response sampled at the end of its slot's high phase
            if (slot_q == last_slot) begin
              state_q <= jtag_gp_pkg::ST_IDLE;
              op_ready_q <= 1'b1;
              rsp_valid_q <= 1'b1;
              rsp_tdo_q <= (fmt_q == jtag_gp_pkg::FMT_OSCAN) ? mdl_sync_q : tdo_sync_q;
            end else begin
              slot_q <= slot_next;
            end
          end
        end
        default: begin
          state_q <= jtag_gp_pkg::ST_IDLE;
          op_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Pin drive per slot; two-wire formats leave TDI floating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_oe_q <= 1'b0;
      mdl_o_q <= 1'b1;
      mdl_oe_q <= 1'b0;
      tdi_o_q <= 1'b0;
      tdi_oe_q <= 1'b0;
    end else begin
      tck_oe_q <= scan_en;
      tdi_o_q <= tdi_q;
      if (state_q != jtag_gp_pkg::ST_RUN) begin
        mdl_o_q <= 1'b1;
        mdl_oe_q <= scan_en;
        tdi_oe_q <= scan_en && (scan_fmt == jtag_gp_pkg::FMT_JSCAN);
      end else begin
        tdi_oe_q <= scan_en && (fmt_q == jtag_gp_pkg::FMT_JSCAN);
        case (fmt_q)
          jtag_gp_pkg::FMT_JSCAN: begin
            mdl_o_q <= tms_q;
            mdl_oe_q <= scan_en;
          end
          default: begin
            // Slot 0 inverted data, slot 1 mode, slot 2 handed to target; driven from the
            // slot being entered so the release has time to pass the return synchroniser
            mdl_o_q <= (slot_next == 2'h0) ? !tdi_q : tms_q;
            mdl_oe_q <= scan_en && (slot_next != jtag_gp_pkg::LAST_SLOT_OSCAN);
          end
        endcase
      end
    end
  end

  assign op_ready = op_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_tdo = rsp_tdo_q;
  assign tck_o = dv.tck;
  assign tck_oe = tck_oe_q;
  assign target_mode_data_line_o = mdl_o_q;
  assign target_mode_data_line_oe = mdl_oe_q;
  assign tdi_o = tdi_o_q;
  assign tdi_oe = tdi_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic seen_active_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_active_q <= 1'b0;
    end else if (gp_active) begin
      seen_active_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_gp_boot_float: assert property (!seen_active_q |-> gp_oe_q == '0)
    else $error("general-purpose pin driven before port enabled");
  a_gp_dir_drive: assert property (gp_active |=> gp_oe_q == $past(gp_dir))
    else $error("general-purpose drive does not follow direction");
  a_gp_off_float: assert property ($fell(gp_active) |=> gp_oe_q == '0
                                   ##1 (gp_oe_q == '0 || $past(gp_active)))
    else $error("general-purpose pins not floated after disable");
  a_gp_exclusive: assert property ((|gp_oe_q) |-> !$past(scan_en) && !$past(spi_en))
    else $error("general-purpose pin driven while scan or serial port on");
  a_div_in_range: assert property (div_n_q >= jtag_gp_pkg::DIV_MIN && div_n_q <= jtag_gp_pkg::DIV_MAX)
    else $error("divider setting outside range");
  a_div_held_run: assert property (dv.run && $past(dv.run) |-> $stable(div_n_q))
    else $error("divider changed during scan operation");
  a_oscan_turn_slot: assert property (dv.run && fmt_q == jtag_gp_pkg::FMT_OSCAN && slot_q == 2'h2
                                      |=> !mdl_oe_q)
    else $error("mode-data line still driven in target slot");
  a_two_wire_tdi: assert property (dv.run && fmt_q != jtag_gp_pkg::FMT_JSCAN |=> !tdi_oe_q)
    else $error("data pin driven in two-wire format");
  a_gp_in_sync: assert property ($past(rst_b, 2) |-> gp_in_val == $past(gp_pin_i, 2))
    else $error("general-purpose input not synchronised in two stages");

  c_jscan_op: cover property (accept && scan_fmt == jtag_gp_pkg::FMT_JSCAN ##[1:300] rsp_valid);
  c_oscan_op: cover property (rsp_valid && fmt_q == jtag_gp_pkg::FMT_OSCAN);
  c_gp_drive: cover property (gp_active ##1 (&gp_oe_q));
  c_gp_release: cover property ((|gp_oe_q) ##1 !gp_active ##1 gp_oe_q == '0);
  c_mscan_second: cover property (dv.rise && slot_q == 2'h1);

endmodule

// ==== rtl/tck_div_if.sv ====
interface tck_div_if #(parameter int DIV_W = 12);
  logic run;
  logic [DIV_W-1:0] div_n;
  logic tck;
  logic rise;
  logic fall;

  modport ctrl (output run, output div_n, input tck, input rise, input fall);
  modport div (input run, input div_n, output tck, output rise, output fall);
endinterface

// ==== rtl/tck_divider.sv ====
module tck_divider #(
  parameter int DIV_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  tck_div_if.div dv
);

  logic [jtag_gp_pkg::TICK_W-1:0] acc_q;
  logic [jtag_gp_pkg::TICK_W:0] acc_sum;
  logic tick;
  logic [DIV_W-1:0] cnt_q;
  logic wrap;
  logic tck_q;
  logic rise_q;

  // Fractional accumulator: 60 ticks per microsecond from a 100 MHz clock.
  // Edges land on the core clock, so fast settings carry up to one cycle of jitter.
  assign acc_sum = {1'b0, acc_q} + {1'b0, jtag_gp_pkg::TICK_STEP};
  assign tick = acc_sum >= {1'b0, jtag_gp_pkg::TICK_MOD};
  assign wrap = tick && (cnt_q == dv.div_n - DIV_W'(1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= jtag_gp_pkg::TICK_W'(acc_sum - {1'b0, jtag_gp_pkg::TICK_MOD});
    end else begin
      acc_q <= acc_sum[jtag_gp_pkg::TICK_W-1:0];
    end
  end

  // Half period is div_n ticks, full period 2*div_n ticks at 60 MHz: 30 MHz / N
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tck_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (!dv.run) begin
      cnt_q <= '0;
      tck_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= wrap && !tck_q;
      if (wrap) begin
        cnt_q <= '0;
        tck_q <= !tck_q;
      end else if (tick) begin
        cnt_q <= cnt_q + DIV_W'(1);
      end
    end
  end

  assign dv.tck = tck_q;
  assign dv.rise = rise_q;
  // Fall flagged in the cycle it is launched, so the next slot's drive and the
  // mode-line release lead the next rise even at the fastest setting
  assign dv.fall = wrap && tck_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_half_period: assert property (dv.run |-> cnt_q < dv.div_n)
    else $error("test clock half period differs from divider setting");

endmodule

// ==== sim/scan_target_model.sv ====
module scan_target_model (
  input wire logic core_clk,
  input wire logic tck,
  input wire logic tck_oe,
  input wire logic line_o,
  input wire logic line_oe,
  output logic line_i,
  input wire logic tdi_o,
  input wire logic tdi_oe,
  output logic tdo,
  input wire logic tdo_val,
  output logic [2:0] hist,
  output logic tdi_seen,
  output int rises,
  output int gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tck_q;
  int cnt;
  // Target takes the shared mode line whenever the probe lets go; pull-up otherwise
  assign line_i = line_oe ? line_o : (tck_oe ? tdo_val : 1'b1);
  // Pull-up on the data return line while no target drives it
  assign tdo = tck_oe ? tdo_val : 1'b1;
  initial begin
    tck_q = 1'b0;
    cnt = 0;
    rises = 0;
    gap = 0;
    hist = 3'h0;
    tdi_seen = 1'b0;
  end
  // Sample on the core clock so rise-to-rise gaps come out in whole cycles
  always @(posedge core_clk) begin
    tck_q <= tck;
    cnt <= cnt + 1;
    if (tck && !tck_q) begin
      gap <= cnt;
      cnt <= 1;
      rises <= rises + 1;
      hist <= {hist[1:0], line_i};
      tdi_seen <= tdi_oe ? tdi_o : 1'b1;
    end
  end
endmodule

// ==== sim/test_jtag_probe_gpio_port.sv ====
module test_jtag_probe_gpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic gp_port_en = 1'b0;
  logic scan_en = 1'b0;
  logic spi_en = 1'b0;
  logic [2:0] gp_dir = 3'h0;
  logic [2:0] gp_out = 3'h0;
  logic [2:0] gp_ext = 3'h7;
  logic [2:0] gp_in_val, pin_o, pin_oe, pin_i;
  logic gp_port_active, op_valid = 1'b0, op_tms = 1'b0, op_tdi = 1'b0, op_ready, rsp_valid;
  logic rsp_tdo, tck_o, tck_oe, line_i, line_o, line_oe, tdi_o, tdi_oe, tdo_i, tdo_val = 1'b0;
  logic tdi_seen;
  jtag_gp_pkg::scan_fmt_t scan_fmt = jtag_gp_pkg::FMT_JSCAN;
  logic [11:0] clk_div_n = 12'h001;
  logic [2:0] hist;
  int rises, gap, fails = 0, check_count = 0, cycles = 0, r0;
  logic got;

  always #5 core_clk = ~core_clk;
  // Pins float to the pull-up unless the bench or the block drives them
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & gp_ext);

  jtag_probe_gpio_port i_dut (.core_clk(core_clk), .rst_b(rst_b), .gp_port_en(gp_port_en),
    .scan_en(scan_en), .spi_en(spi_en), .gp_dir(gp_dir), .gp_out(gp_out),
    .gp_in_val(gp_in_val), .gp_port_active(gp_port_active), .scan_fmt(scan_fmt),
    .clk_div_n(clk_div_n), .op_valid(op_valid), .op_tms(op_tms), .op_tdi(op_tdi),
    .op_ready(op_ready), .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo), .tck_o(tck_o),
    .tck_oe(tck_oe), .target_mode_data_line_i(line_i), .target_mode_data_line_o(line_o),
    .target_mode_data_line_oe(line_oe), .tdi_o(tdi_o), .tdi_oe(tdi_oe), .tdo_i(tdo_i),
    .gp_pin_zero_i(pin_i[0]), .gp_pin_zero_o(pin_o[0]), .gp_pin_zero_oe(pin_oe[0]),
    .gp_pin_one_i(pin_i[1]), .gp_pin_one_o(pin_o[1]), .gp_pin_one_oe(pin_oe[1]),
    .gp_pin_two_i(pin_i[2]), .gp_pin_two_o(pin_o[2]), .gp_pin_two_oe(pin_oe[2]));

  scan_target_model i_target (.core_clk(core_clk), .tck(tck_o), .tck_oe(tck_oe),
    .line_o(line_o), .line_oe(line_oe), .line_i(line_i), .tdi_o(tdi_o), .tdi_oe(tdi_oe),
    .tdo(tdo_i), .tdo_val(tdo_val), .hist(hist), .tdi_seen(tdi_seen), .rises(rises),
    .gap(gap));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One scan bit; the divider input is disturbed right after the take
  task automatic scan_op(input logic [1:0] fmt, input logic tms, input logic tdi,
                         input logic [11:0] n);
    int i;
    @(posedge core_clk);
    scan_fmt <= jtag_gp_pkg::scan_fmt_t'(fmt);
    op_tms <= tms;
    op_tdi <= tdi;
    clk_div_n <= n;
    op_valid <= 1'b1;
    r0 = rises;
    do @(posedge core_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    clk_div_n <= 12'h001;
    for (i = 0; i < 40000 && rsp_valid !== 1'b1; i++)
      wait_cyc(1);
    got = rsp_tdo;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    // Ceiling well above the slowest divider setting
    if (cycles == 80000) begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int f, k;
    logic [2:0] e;
    wait_cyc(10);
    chk("pin enables in reset", 3'h0, pin_oe);
    rst_b <= 1'b1;
    gp_dir <= 3'h7;
    gp_out <= 3'h5;
    wait_cyc(3);
    chk("pin enables port off", 3'h0, pin_oe);
    gp_port_en <= 1'b1;
    wait_cyc(3);
    chk("pin enables", 3'h7, pin_oe);
    chk("pin values", 3'h5, pin_o);
    chk("port active", 1'b1, gp_port_active);
    gp_dir <= 3'h2;
    wait_cyc(3);
    chk("pin enables one", 3'h2, pin_oe);
    gp_dir <= 3'h0;
    gp_ext <= 3'h2;
    wait_cyc(4);
    chk("pin inputs", 3'h2, gp_in_val);
    gp_dir <= 3'h7;
    gp_ext <= 3'h7;
    wait_cyc(3);
    gp_port_en <= 1'b0;
    wait_cyc(3);
    chk("pin enables disabled", 3'h0, pin_oe);
    gp_port_en <= 1'b1;
    spi_en <= 1'b1;
    wait_cyc(3);
    chk("port active spi", 1'b0, gp_port_active);
    chk("pin enables spi", 3'h0, pin_oe);
    spi_en <= 1'b0;
    scan_en <= 1'b1;
    wait_cyc(3);
    chk("port active scan", 1'b0, gp_port_active);
    chk("pin enables scan", 3'h0, pin_oe);
    chk("tck enable on", 1'b1, tck_oe);
    // Pin two stays a plain pin here; no reset duty is exercised
    for (f = 0; f < 3; f++) begin
      for (k = 0; k < 4; k++) begin
        tdo_val <= k[0];
        scan_op(f[1:0], k[1], k[0] ^ k[1], 12'h001);
        chk("tck pulses", f + 1, rises - r0);
        chk("reply bit", k[0], got);
        e = (f == 0) ? {2'h0, k[1]} : (f == 1) ? {1'b0, ~(k[0] ^ k[1]), k[1]}
                                                 : {~(k[0] ^ k[1]), k[1], k[0]};
        chk("mode line slots", e, (f == 0) ? {2'h0, hist[0]} : (f == 1) ? {1'b0, hist[1:0]}
                                                                      : hist);
        if (f == 0)
          chk("data pin", k[0] ^ k[1], tdi_seen);
        chk("data pin enable", f == 0, tdi_oe);
      end
    end
    // Host parks the target in a four-wire format before the port is shut
    scan_op(2'h1, 1'b0, 1'b0, 12'h006);
    chk("gap at six", 1, gap * 3 >= 57 && gap * 3 <= 63);
    scan_op(2'h1, 1'b0, 1'b0, 12'h000);
    chk("gap at zero", 1, gap >= 3 && gap <= 4);
    scan_op(2'h1, 1'b0, 1'b0, 12'h0ea6);
    chk("gap at max", 1, gap >= 12499 && gap <= 12501);
    scan_op(2'h0, 1'b1, 1'b1, 12'h001);
    scan_en <= 1'b0;
    wait_cyc(3);
    chk("tck enable off", 1'b0, tck_oe);
    give_verdict();
  end
endmodule
